// File: verilog/pbs_sram.sv
/*
 Pipelined burst synchronous SRAM, 128K x 32, common data bus.
 Holds the input capture, burst counter, self-timed write stage,
 registered read path, output enable masking and sleep logic.
 Assumes the far party is synchronous logic on clk; the output enable,
 sleep request and burst order strap come from pins and are synchronised.
*/
// Function
// - Register all synchronous inputs and read outputs
// - Load address only on an accepted strobe
// - Address picks one of 128K words
// - Byte write touches only selected lanes
// - Global write writes all four lanes
// - Selected only when all three selects active
// - Processor strobe ignored while select one high
// - Processor strobe wins when both strobes low
// - Strobe loads two low bits into counter
// - Counter advances on each low advance input in a selected cycle without a strobe
// - Strap low linear, high interleaved order
// - Output enable low drives, high tristates
// - First read cycle from deselect stays tristated
// - Read starts on strobe, select, no write
// - Read data one cycle after address capture
// - Bursts run three-one-one-one cycles
// - Back-to-back single reads are accepted
// - Deselect with strobe tristates outputs at once
// - Writes are registered then self-timed internally
// - Sleep request holds data, blocks access
// - Interleaved order XORs start with count
// - Linear order counts modulo four upward
// - Processor write samples controls second edge
// - Any detected write tristates the outputs
`timescale 1ns/10ps
`default_nettype none
module pbs_sram
   import pbs_pkg::*;
(
   input wire logic clk, // System clock, 40 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [16:0] addr, // Word address
   input wire logic [31:0] dq_in, // Data bus as seen at the pins
   output logic [31:0] dq_out, // Registered read data
   output logic dq_oe, // High while the device drives the bus
   input wire logic cpu_addr_strobe_n, // Processor address strobe
   input wire logic ctrl_addr_strobe_n, // Controller address strobe
   input wire logic burst_advance_n, // Burst advance
   input wire logic all_bytes_write_n, // Global write
   input wire logic lane_write_enable_n, // Byte write enable
   input wire logic [3:0] lane_select_n, // Byte lane selects
   input wire logic chip_sel_one_n, // Chip select one
   input wire logic chip_sel_two, // Chip select two
   input wire logic chip_sel_three_n, // Chip select three
   input wire logic out_enable_n, // Asynchronous output enable
   input wire logic sleep_request, // Asynchronous sleep input
   input wire logic burst_order_strap, // High or open selects interleaved
   output logic sleep_active // Sleep state reached
);

   // Burst address bits from start value and step count
   function automatic logic [1:0] burst_bits(input logic [1:0] start, input logic [1:0] cnt,
                                             input logic linear);
      if (linear) begin
         burst_bits = start + cnt;
      end else begin
         burst_bits = start ^ cnt;
      end
   endfunction

   // Reset release chain
   logic [1:0] rst_sync_q;
   logic rst_n;
   // Pin synchroniser stages
   logic [SYNC_W-1:0] sy1_q;
   logic [SYNC_W-1:0] sy2_q;
   // Captured access state
   logic [16:0] addr_q; // Registered external address
   logic [1:0] start_q; // Burst start bits
   logic [1:0] k_q; // Burst step count
   logic sel_q; // Device selected by last load
   // Write stage
   logic wr_q;
   logic [16:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wlanes_q;
   // Read stage
   logic rv_q;
   logic [16:0] raddr_q;
   logic [31:0] dq_out_q;
   logic dq_oe_q;
   // Storage array, not reset: contents survive reset and sleep
   logic [31:0] mem_q [0:WORDS-1];

   // Decoded cycle
   logic awake; // Not in sleep
   logic linear; // Linear burst order chosen
   logic oe_on; // Output enable asserted
   logic ce_ok; // All selects active at the pins
   logic p_take; // Processor strobe honoured
   logic load_now; // A new address is loaded this edge
   logic [3:0] lanes_now; // Lanes the write controls ask for
   logic wr_now; // Write detected this edge
   logic rd_now; // Read access this edge
   logic step; // Counter advances this edge
   logic first_rd; // Read emerging from deselect
   logic desel_now; // Strobe with inactive selects
   logic [1:0] k_use; // Step count used this edge
   logic [16:0] use_addr; // Array address used this edge
   logic [31:0] rd_word; // Array word under the read address

   // Reset leaves through two flip-flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= RSTSYNC_RST;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Two-stage synchroniser for the asynchronous pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= SYNC_RST;
         sy2_q <= SYNC_RST;
      end else begin
         sy1_q <= {out_enable_n, sleep_request, burst_order_strap};
         sy2_q <= sy1_q;
      end
   end

   // Synchronised pin levels; sleep takes two clocks to enter or leave
   assign awake = !sy2_q[SYNC_SLEEP];
   assign linear = !sy2_q[SYNC_MODE];
   assign oe_on = !sy2_q[SYNC_OE];

   // Select and strobe decode, on pins captured at this edge
   assign ce_ok = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
   // Processor strobe counts only with select one low; it then beats the controller strobe
   assign p_take = !cpu_addr_strobe_n && !chip_sel_one_n;
   assign load_now = awake && (p_take || !ctrl_addr_strobe_n);
   assign desel_now = load_now && !ce_ok;

   // Write lane decode: global write overrides the lane controls
   always_comb begin
      if (!all_bytes_write_n) begin
         lanes_now = LANE_ALL;
      end else if (!lane_write_enable_n) begin
         lanes_now = ~lane_select_n;
      end else begin
         lanes_now = LANE_NONE;
      end
   end

   // Cycle classification
   always_comb begin
      if (!awake) begin
         // Nothing starts or continues while asleep
         wr_now = 1'b0;
      end else if (load_now) begin
         // Processor-strobed load ignores write controls on its first edge
         wr_now = !p_take && ce_ok && (lanes_now != LANE_NONE);
      end else begin
         // Continue or suspend cycle: second edge of a processor write lands here
         wr_now = sel_q && (lanes_now != LANE_NONE);
      end
   end

   // Read when selected and no write asked for
   assign rd_now = awake && (load_now ? ce_ok : sel_q) && !wr_now;
   assign first_rd = rd_now && load_now && !sel_q;
   // Advance input only counts on cycles that load no address
   assign step = awake && !load_now && sel_q && !burst_advance_n;
   assign k_use = step ? k_q + BURST_ONE : k_q;

   // New address goes straight to the array; bursts change only the low bits
   always_comb begin
      if (load_now) begin
         use_addr = addr;
      end else begin
         use_addr = {addr_q[ADDR_W-1:BURST_W], burst_bits(start_q, k_use, linear)};
      end
   end

   // Address register, select state and burst counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= ADDR_RST;
         start_q <= BURST_ZERO;
         k_q <= BURST_ZERO;
         sel_q <= 1'b0;
      end else if (!awake) begin
         // Sleep drops any pending access; device comes back deselected
         sel_q <= 1'b0;
      end else if (load_now) begin
         addr_q <= addr;
         start_q <= addr[BURST_W-1:0];
         k_q <= BURST_ZERO;
         sel_q <= ce_ok;
      end else if (step) begin
         k_q <= k_q + BURST_ONE;
      end
   end

   // Write stage: address, data and lanes registered, array written next edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         waddr_q <= ADDR_RST;
         wdata_q <= DATA_RST;
         wlanes_q <= LANE_NONE;
      end else begin
         wr_q <= wr_now;
         waddr_q <= use_addr;
         wdata_q <= dq_in;
         wlanes_q <= lanes_now;
      end
   end

   // Self-timed array write; untouched lanes keep their old bytes
   always_ff @(posedge clk) begin
      if (wr_q) begin
         for (int i = 0; i < LANES; i++) begin
            if (wlanes_q[i]) begin
               mem_q[waddr_q][i*LANE_W +: LANE_W] <= wdata_q[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Read stage: address held one cycle before the array is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rv_q <= 1'b0;
         raddr_q <= ADDR_RST;
      end else begin
         rv_q <= rd_now;
         raddr_q <= use_addr;
      end
   end

   assign rd_word = mem_q[raddr_q];

   // Output register; a write just ahead in the same word may still be in flight,
   // but it lands one edge before the read stage reaches the array
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_out_q <= DATA_RST;
      end else if (rv_q) begin
         dq_out_q <= rd_word;
      end
   end

   // Output drive: enable, write detect, deselect, sleep and first-cycle mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_oe_q <= 1'b0;
      end else begin
         // Enable is synchronised, so it acts three clocks late; a trade for clean timing
         dq_oe_q <= rv_q && oe_on && awake && !wr_now
                    && !desel_now && !first_rd;
      end
   end

   assign dq_out = dq_out_q;
   assign dq_oe = dq_oe_q;
   assign sleep_active = sy2_q[SYNC_SLEEP];

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Read accepted, then held, then shown
   sequence s_read_start;
      rd_now && !wr_now;
   endsequence
   sequence s_read_shown;
      rv_q ##1 (dq_out_q == $past(rd_word));
   endsequence
   // Burst step with counter moving by one
   sequence s_step;
      step;
   endsequence

   property p_read_path;
      s_read_start |=> s_read_shown;
   endproperty
   property p_step_moves;
      s_step |=> (k_q == $past(k_q) + BURST_ONE) && $stable(addr_q);
   endproperty

   a_read_latency: assert property (p_read_path)
      else $error("Read data not shown one cycle after capture");
   a_addr_load: assert property (load_now |=> (addr_q == $past(addr))
      && (start_q == $past(addr[1:0])) && (k_q == BURST_ZERO))
      else $error("Accepted strobe did not load address and counter");
   a_addr_hold: assert property (!load_now |=> $stable(addr_q) && $stable(start_q))
      else $error("Address register changed without a strobe");
   a_cpu_ignored: assert property (awake && !cpu_addr_strobe_n && chip_sel_one_n
      && ctrl_addr_strobe_n |-> !load_now)
      else $error("Processor strobe acted with select one high");
   a_cpu_priority: assert property (load_now && p_take && !ctrl_addr_strobe_n && ce_ok |=> !wr_q && rv_q)
      else $error("Controller strobe acted beside processor strobe");
   a_global_write: assert property (wr_now && !all_bytes_write_n |=> wr_q && (wlanes_q == LANE_ALL))
      else $error("Global write did not cover all lanes");
   a_write_tristate: assert property (wr_now |=> !dq_oe_q)
      else $error("Outputs driven during a write");
   a_first_masked: assert property (first_rd |=> !dq_oe_q
      ##1 (dq_oe_q == $past(oe_on && awake && rv_q && !wr_now && !desel_now && !first_rd)))
      else $error("Outputs not masked on first read from deselect");
   // A fresh strobe may follow the deselect at once, so only the deselect edge and the one after it are judged
   a_deselect_off: assert property (desel_now |=> (!dq_oe_q && !rv_q) ##1 !dq_oe_q)
      else $error("Outputs not off after deselect");
   a_burst_step: assert property (p_step_moves)
      else $error("Burst counter did not step by one");
   a_burst_wrap: assert property (!load_now && sel_q |-> use_addr[16:2] == addr_q[16:2])
      else $error("Burst left its aligned group of four");
   a_linear_order: assert property (!load_now && linear |-> use_addr[1:0] == 2'(start_q + k_use))
      else $error("Linear burst order wrong");
   a_sleep_quiet: assert property (!awake |=> !dq_oe_q && !wr_q && !sel_q)
      else $error("Access or drive during sleep");

   // Output enable high keeps the pins released; the synchronised level is the one that counts
   a_oe_off: assert property (!oe_on |=> !dq_oe_q)
      else $error("Outputs driven with output enable high");
   // Byte write lands only in the lanes whose selects were low
   a_lane_write: assert property (wr_now && all_bytes_write_n && !lane_write_enable_n
      |=> wr_q && (wlanes_q == ~$past(lane_select_n)))
      else $error("Byte write lanes differ from the selects");
   // Whole-word write is in the array one edge after it was registered
   a_self_timed: assert property (wr_q && (wlanes_q == LANE_ALL)
      |=> mem_q[$past(waddr_q)] == $past(wdata_q))
      else $error("Registered write did not reach the array");
   // Interleaved order flips the start bits by the step count
   a_interleave_order: assert property (!load_now && !linear |-> use_addr[1:0] == (start_q ^ k_use))
      else $error("Interleaved burst order wrong");
   // Each fresh strobe read starts its own read stage from the pin address
   a_single_read: assert property (load_now && rd_now |=> rv_q && (raddr_q == $past(addr)))
      else $error("Back-to-back read did not take the new address");
   // Nothing is loaded or written while asleep
   a_sleep_no_load: assert property (!awake |-> !load_now && !wr_now)
      else $error("Access accepted during sleep");

endmodule // pbs_sram
`default_nettype wire

// File: verilog/pbs_pkg.sv
/*
 Constants shared by the pipelined burst synchronous SRAM block:
 array geometry, byte lanes, burst counter codes and reset values.
 Assumes a single clock domain and an active-low reset.
*/
`default_nettype none
package pbs_pkg;
   // Array geometry: 128K words of 32 bits
   localparam int ADDR_W = 17;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int WORDS = 131072;
   // Burst counter width and codes
   localparam int BURST_W = 2;
   localparam logic [1:0] BURST_ZERO = 2'h0;
   localparam logic [1:0] BURST_ONE = 2'h1;
   // Lane masks for whole-word and empty writes
   localparam logic [3:0] LANE_ALL = 4'hf;
   localparam logic [3:0] LANE_NONE = 4'h0;
   // Asynchronous pin synchroniser: {out_enable_n, sleep_request, burst_order_strap}
   localparam int SYNC_W = 3;
   localparam int SYNC_OE = 2;
   localparam int SYNC_SLEEP = 1;
   localparam int SYNC_MODE = 0;
   localparam logic [2:0] SYNC_RST = 3'h5;
   // Reset values of the datapath
   localparam logic [16:0] ADDR_RST = 17'h00000;
   localparam logic [31:0] DATA_RST = 32'h00000000;
   localparam logic [1:0] RSTSYNC_RST = 2'h0;
   localparam logic [1:0] RSTSYNC_ON = 2'h3;
endpackage
`default_nettype wire

// File: tb/pbs_bus_model.sv
/*
 Far-party data pins: resolves the shared data bus.
 Assumes the bench raises drv_en only while it owns the bus.
*/
`timescale 1ns/10ps
`default_nettype none
module pbs_bus_model (
   input wire logic clk, // Bus clock
   input wire logic drv_en, // Far party drives
   input wire logic [31:0] drv_data, // Far party data
   input wire logic [31:0] dq_out, // Device data
   input wire logic dq_oe, // Device drives
   output logic [31:0] dq_in // Level at the pins
);
   logic [31:0] last_q = 32'h00000000; // Last wire level
   // A released bus must not look like stale data
   always_comb begin
      if (drv_en) begin
         dq_in = drv_data;
      end else if (dq_oe) begin
         dq_in = dq_out;
      end else begin
         dq_in = ~last_q;
      end
   end
   // Keep the level for the next floating cycle
   always_ff @(posedge clk) begin
      last_q <= dq_in;
   end
endmodule // pbs_bus_model
`default_nettype wire

// File: tb/testbench.sv
/*
 Self-checking bench for the burst SRAM: writes, reads, bursts, selects, sleep.
 Assumes inputs change at the falling edge and the array model starts empty.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pbs_pkg::*;
   localparam int CYC_LIMIT = 4000; // Watchdog span in cycles
   logic clk, rstn, cpu_n, ctrl_n, adv_n, allw_n, lwe_n, sel1_n, sel2, sel3_n;
   logic oen, slp, strap, drv_en, dq_oe, sleep_active;
   logic [3:0] lsel_n;
   logic [16:0] addr;
   logic [31:0] drv_data, dq_in, dq_out;
   logic [31:0] mem [int]; // Expected array contents
   int failures = 0;
   int check_count = 0;
   pbs_sram i_pbs_sram (.clk(clk), .rstn(rstn), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .cpu_addr_strobe_n(cpu_n), .ctrl_addr_strobe_n(ctrl_n),
      .burst_advance_n(adv_n), .all_bytes_write_n(allw_n), .lane_write_enable_n(lwe_n),
      .lane_select_n(lsel_n), .chip_sel_one_n(sel1_n), .chip_sel_two(sel2),
      .chip_sel_three_n(sel3_n), .out_enable_n(oen), .sleep_request(slp),
      .burst_order_strap(strap), .sleep_active(sleep_active));
   pbs_bus_model i_pbs_bus_model (.clk(clk), .drv_en(drv_en), .drv_data(drv_data),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;
   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #(25 * CYC_LIMIT);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
      end
   endtask
   // One rising edge, then settle at the falling edge
   task automatic step();
      @(posedge clk);
      @(negedge clk);
   endtask
   // Bus parked: no strobes, device selected, bus released
   task automatic idle();
      cpu_n = 1'b1;
      ctrl_n = 1'b1;
      adv_n = 1'b1;
      allw_n = 1'b1;
      lwe_n = 1'b1;
      lsel_n = 4'hf;
      sel1_n = 1'b0;
      sel2 = 1'b1;
      sel3_n = 1'b0;
      drv_en = 1'b0;
   endtask
   // Expected burst address bits for step k
   function automatic logic [1:0] seq(input logic [1:0] s, input int k, input logic lin);
      return lin ? s + 2'(k) : s ^ 2'(k);
   endfunction
   // Controller-strobe write; byte enable low so the global case must ignore lanes
   task automatic wr_c(input logic [16:0] a, input logic [31:0] d, input logic [3:0] ls,
                       input logic g);
      ctrl_n = 1'b0;
      addr = a;
      allw_n = ~g;
      lwe_n = 1'b0;
      lsel_n = ls;
      drv_en = 1'b1;
      drv_data = d;
      step();
      chk_b(dq_oe, 1'b0, "write drive");
      idle();
      step();
      for (int i = 0; i < 4; i++) begin
         if (g || !ls[i]) begin
            mem[a][8*i+:8] = d[8*i+:8];
         end
      end
   endtask
   // Back-to-back single reads, one fresh strobe per edge
   task automatic rd(input logic [16:0] a[$]);
      foreach (a[i]) begin
         cpu_n = 1'b0;
         addr = a[i];
         step();
         if (i > 0) chk_w(dq_out, mem[a[i-1]], "read");
      end
      idle();
      step();
      chk_w(dq_out, mem[a[a.size()-1]], "read last");
      chk_b(dq_oe, 1'b1, "read drive");
   endtask
   // Four-word burst from a, advance low three times
   task automatic br(input logic [16:0] a, input logic lin);
      cpu_n = 1'b0;
      addr = a;
      step();
      cpu_n = 1'b1;
      for (int k = 0; k < 4; k++) begin
         adv_n = (k < 3) ? 1'b0 : 1'b1;
         step();
         chk_w(dq_out, mem[{a[16:2], seq(a[1:0], k, lin)}], "burst");
      end
   endtask
   // Main sequence
   initial begin
      logic [16:0] b;
      logic [31:0] d, old;
      logic [2:0] bad [3];
      bad = '{3'b110, 3'b000, 3'b011};
      clk = 1'b0;
      rstn = 1'b0;
      strap = 1'b1;
      oen = 1'b0;
      slp = 1'b0;
      addr = ADDR_RST;
      drv_data = DATA_RST;
      idle();
      void'($urandom(46));
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (6) step();
      for (int j = 0; j < 2; j++) begin
         b = j ? 17'h1fffc : (17'($urandom) & 17'h1fffc);
         for (int k = 0; k < 4; k++) wr_c(b + 17'(k), $urandom, 4'($urandom), 1'b1);
         rd('{b + 17'h3, b, b + 17'h2, b + 17'h1});
      end
      $display("test global write done");
      for (int i = 0; i < 8; i++) begin
         wr_c(b + 17'(i % 4), $urandom, 4'($urandom % 15), 1'b0);
         rd('{b + 17'(i % 4)});
      end
      $display("test lane write done");
      for (int l = 0; l < 2; l++) begin
         strap = ~l[0];
         repeat (4) step();
         for (int s = 0; s < 4; s++) br(b + 17'(s), l[0]);
      end
      strap = 1'b1;
      repeat (4) step();
      $display("test burst done");
      cpu_n = 1'b0;
      ctrl_n = 1'b0;
      addr = b;
      allw_n = 1'b0;
      drv_en = 1'b1;
      drv_data = ~mem[b];
      step();
      idle();
      step();
      cpu_n = 1'b0;
      allw_n = 1'b0;
      step();
      d = $urandom;
      cpu_n = 1'b1;
      adv_n = 1'b0;
      drv_en = 1'b1;
      drv_data = d;
      step();
      idle();
      step();
      mem[{b[16:2], seq(b[1:0], 1, 1'b0)}] = d;
      rd('{b, {b[16:2], seq(b[1:0], 1, 1'b0)}});
      $display("test processor write done");
      rd('{b});
      cpu_n = 1'b0;
      sel1_n = 1'b1;
      addr = b + 17'h1;
      step();
      chk_b(dq_oe, 1'b1, "ignored strobe");
      chk_w(dq_out, mem[b], "ignored strobe");
      idle();
      step();
      chk_b(dq_oe, 1'b1, "still selected after ignored strobe");
      for (int i = 0; i < 3; i++) begin
         rd('{b});
         {sel1_n, sel2, sel3_n} = bad[i];
         ctrl_n = 1'b0;
         step();
         chk_b(dq_oe, 1'b0, "deselect");
         idle();
         step();
      end
      cpu_n = 1'b0;
      addr = b;
      step();
      chk_b(dq_oe, 1'b0, "first cycle");
      idle();
      step();
      chk_b(dq_oe, 1'b1, "second cycle");
      oen = 1'b1;
      repeat (3) step();
      cpu_n = 1'b0;
      step();
      idle();
      step();
      chk_b(dq_oe, 1'b0, "enable high");
      oen = 1'b0;
      repeat (3) step();
      $display("test selects done");
      old = mem[b];
      slp = 1'b1;
      repeat (4) step();
      chk_b(sleep_active, 1'b1, "sleep");
      wr_c(b, ~old, 4'hf, 1'b1);
      mem[b] = old;
      slp = 1'b0;
      repeat (4) step();
      chk_b(sleep_active, 1'b0, "wake");
      rd('{b});
      $display("test sleep done");
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
